// ===== verilog/irq_pkg.sv
package irq_pkg;

	// ========================================================================
	// Register map of the interrupt controller.
	// ========================================================================
	localparam logic [15:0] ADDR_TIMER_CONTROL_REG = 16'h0088;
	localparam logic [15:0] ADDR_EXT_IRQ_FLAGS = 16'h0091;
	localparam logic [15:0] ADDR_UART1_FLAGS = 16'h0098;
	localparam logic [15:0] ADDR_IRQ_ENABLE_BASE = 16'h00a8;
	localparam logic [15:0] ADDR_IRQ_PRIORITY_BASE = 16'h00b8;
	localparam logic [15:0] ADDR_TIMER2_FLAGS = 16'h00c8;
	localparam logic [15:0] ADDR_IRQ_ENABLE_EXTENDED = 16'h00e8;
	localparam logic [15:0] ADDR_IRQ_PRIORITY_EXTENDED = 16'h00f8;
	localparam logic [15:0] ADDR_EXT_IRQ_CLOCK_GATE = 16'h2d01;
	localparam logic [15:0] ADDR_PIN_MODE = 16'h2d02;
	// Group g has its event enables at base + 2g and its flags at base + 2g + 1.
	localparam logic [15:0] ADDR_GROUP_BASE = 16'h2d10;

	// ========================================================================
	// Field positions.
	// ========================================================================
	localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
	localparam int PIN0_MODE_BIT = 0;
	localparam int PIN0_FLAG_BIT = 1;
	localparam int PIN1_MODE_BIT = 2;
	localparam int PIN1_FLAG_BIT = 3;
	localparam int TIMER0_FLAG_BIT = 5;
	localparam int TIMER1_FLAG_BIT = 7;
	localparam int TIMER2_FLAG_BIT = 7;
	localparam int UART1_RX_FLAG_BIT = 0;
	localparam int UART1_TX_FLAG_BIT = 1;
	localparam int EXT_FLAG_LSB = 4;

	// ========================================================================
	// Sizes, reset values and vector layout.
	// ========================================================================
	localparam int NUM_GROUPS = 4;
	localparam int NUM_IRQS = 12;
	localparam int NUM_PINS = 4;
	localparam int NUM_GROUP_EVENTS = 30;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] GATE_RESET = 8'h0f;
	localparam logic [3:0] PIN_IDLE = 4'hf;
	localparam logic [2:0] VECTOR_LOW_BITS = 3'h3;

	typedef struct packed {
		logic valid;
		logic tier;
		logic [3:0] number;
		logic [7:0] vector;
	} irq_req_t;

endpackage

// ===== verilog/ext_irq_group.sv
`timescale 1ns/1ps

module ext_irq_group (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] event_in,
	input wire logic gate_open_in,
	input wire logic wr_enable_in,
	input wire logic wr_flag_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] enable_out,
	output logic [7:0] flag_out,
	output logic req_out
);

	logic [7:0] enable_q;
	logic [7:0] enable_d;
	logic [7:0] flag_q;
	logic [7:0] flag_d;

	always_comb begin
		enable_d = wr_enable_in ? wdata_in : enable_q;
		flag_d = wr_flag_in ? wdata_in : flag_q;
		// A gated group captures no new events; an arriving event beats a clear.
		if (gate_open_in) begin
			flag_d = flag_d | event_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			enable_q <= irq_pkg::RESET_BYTE;
			flag_q <= irq_pkg::RESET_BYTE;
		end else begin
			enable_q <= enable_d;
			flag_q <= flag_d;
		end
	end

	assign enable_out = enable_q;
	assign flag_out = flag_q;
	assign req_out = |(enable_q & flag_q);

endmodule

// ===== verilog/irq_controller.sv
`timescale 1ns/1ps

// Operation
// - Any system reset cause returns every controller register to default.
// - Runs only on its own domain clock, halted in sleep states.
// - Each extended interrupt group is gated independently by register 0x2D01.
// - Accepts 39 distinct events from pins and peripherals.
// - Four pin inputs, each on low level or falling edge.
// - Several peripheral events share one extended interrupt and vector.
// - Extended request needs global, own and event enables plus both flags.
// - Two tiers set at 0xB8 and 0xF8; tier 1 beats tier 0.
// - Within a tier the lowest polling number is served first.
// - Only a higher tier preempts; return resumes the interrupted service.
// - Pin interrupt 0 vectors to 03h, enable bit 0, flag in timer control.
module irq_controller (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic power_on_brownout_reset_in,
	input wire logic external_reset_pin_in,
	input wire logic watchdog_timer_reset_in,
	input wire logic power_recovery_in,
	input wire logic wakeup_in,
	input wire logic debug_event_in,
	input wire logic [3:0] ext_pin_n_in,
	input wire logic timer0_overflow_in,
	input wire logic timer1_overflow_in,
	input wire logic timer2_event_in,
	input wire logic uart1_rx_in,
	input wire logic uart1_tx_in,
	input wire logic [29:0] group_event_in,
	input wire logic [15:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic irq_ack_in,
	input wire logic irq_return_in,
	output logic [7:0] sfr_rdata_out,
	output irq_pkg::irq_req_t irq_req_out,
	output logic [1:0] in_service_out
);

	// ========================================================================
	// Reset and state.
	// ========================================================================
	logic reset_all;
	logic [7:0] ie_q, ie_d, eie_q, eie_d, pri_base_q, pri_base_d;
	logic [7:0] pri_ext_q, pri_ext_d;
	logic [7:0] tctl_q, tctl_d, exif_q, exif_d, t2_q, t2_d;
	logic [7:0] uart1_q, uart1_d, gate_q, gate_d, pin_mode_q, pin_mode_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] pin_prev_q;
	logic [1:0] in_service_q, in_service_d;
	irq_pkg::irq_req_t req_q, req_d;

	// The clock port is the controller's own domain clock.
	assign reset_all = rst_in | power_on_brownout_reset_in
		| external_reset_pin_in | watchdog_timer_reset_in
		| power_recovery_in | wakeup_in | debug_event_in;

	// ========================================================================
	// Pin event detection.
	// ========================================================================
	logic [3:0] pin_edge_mode, pin_event;
	always_comb begin
		pin_edge_mode = {pin_mode_q[3:2],
			tctl_q[irq_pkg::PIN1_MODE_BIT], tctl_q[irq_pkg::PIN0_MODE_BIT]};
		// Edge mode catches a falling edge; level mode follows a low pin.
		pin_event = (pin_edge_mode & pin_prev_q & ~ext_pin_n_in)
			| (~pin_edge_mode & ~ext_pin_n_in);
	end

	// ========================================================================
	// Extended interrupt groups.
	// ========================================================================
	logic [31:0] grp_events;
	logic [3:0] grp_req;
	logic [7:0] grp_en [irq_pkg::NUM_GROUPS];
	logic [7:0] grp_flag [irq_pkg::NUM_GROUPS];
	// Pins 2 and 3 join the last group: 2 + 5 + 30 + 2 = 39 events.
	assign grp_events = {pin_event[3:2], group_event_in};

	genvar g;
	generate
		for (g = 0; g < irq_pkg::NUM_GROUPS; g++) begin : gen_group
			ext_irq_group u_group (
				.clk_sys_in(clk_sys_in),
				.rst_in(reset_all),
				.event_in(grp_events[8*g +: 8]),
				.gate_open_in(gate_q[g]),
				.wr_enable_in(sfr_wr_in
					&& sfr_addr_in == irq_pkg::ADDR_GROUP_BASE + 16'(2*g)),
				.wr_flag_in(sfr_wr_in
					&& sfr_addr_in == irq_pkg::ADDR_GROUP_BASE + 16'(2*g+1)),
				.wdata_in(sfr_wdata_in),
				.enable_out(grp_en[g]),
				.flag_out(grp_flag[g]),
				.req_out(grp_req[g])
			);
		end
	endgenerate

	// ========================================================================
	// Register writes and hardware flag updates.
	// ========================================================================
	logic ack_take;
	assign ack_take = irq_ack_in & req_q.valid;

	function automatic logic [7:0] wr_val(input logic [15:0] a,
		input logic [7:0] q);
		wr_val = (sfr_wr_in && sfr_addr_in == a) ? sfr_wdata_in : q;
	endfunction

	always_comb begin
		ie_d = wr_val(irq_pkg::ADDR_IRQ_ENABLE_BASE, ie_q);
		eie_d = wr_val(irq_pkg::ADDR_IRQ_ENABLE_EXTENDED, eie_q);
		pri_base_d = wr_val(irq_pkg::ADDR_IRQ_PRIORITY_BASE,
			pri_base_q);
		pri_ext_d = wr_val(irq_pkg::ADDR_IRQ_PRIORITY_EXTENDED,
			pri_ext_q);
		gate_d = wr_val(irq_pkg::ADDR_EXT_IRQ_CLOCK_GATE, gate_q);
		pin_mode_d = wr_val(irq_pkg::ADDR_PIN_MODE, pin_mode_q);
		tctl_d = wr_val(irq_pkg::ADDR_TIMER_CONTROL_REG, tctl_q);
		t2_d = wr_val(irq_pkg::ADDR_TIMER2_FLAGS, t2_q);
		uart1_d = wr_val(irq_pkg::ADDR_UART1_FLAGS, uart1_q);
		exif_d = wr_val(irq_pkg::ADDR_EXT_IRQ_FLAGS, exif_q);
		// Edge-type flags clear when their vector is taken.
		if (ack_take) begin
			case (req_q.number)
				4'h0: tctl_d[irq_pkg::PIN0_FLAG_BIT] = 1'b0;
				4'h1: tctl_d[irq_pkg::TIMER0_FLAG_BIT] = 1'b0;
				4'h2: tctl_d[irq_pkg::PIN1_FLAG_BIT] = 1'b0;
				4'h3: tctl_d[irq_pkg::TIMER1_FLAG_BIT] = 1'b0;
				default: ;
			endcase
		end
		// Hardware sets win over software or acknowledge clears.
		tctl_d[irq_pkg::PIN0_FLAG_BIT] = pin_edge_mode[0]
			? (tctl_d[irq_pkg::PIN0_FLAG_BIT] | pin_event[0])
			: pin_event[0];
		tctl_d[irq_pkg::PIN1_FLAG_BIT] = pin_edge_mode[1]
			? (tctl_d[irq_pkg::PIN1_FLAG_BIT] | pin_event[1])
			: pin_event[1];
		tctl_d[irq_pkg::TIMER0_FLAG_BIT] = tctl_d[irq_pkg::TIMER0_FLAG_BIT]
			| timer0_overflow_in;
		tctl_d[irq_pkg::TIMER1_FLAG_BIT] = tctl_d[irq_pkg::TIMER1_FLAG_BIT]
			| timer1_overflow_in;
		t2_d[irq_pkg::TIMER2_FLAG_BIT] = t2_d[irq_pkg::TIMER2_FLAG_BIT]
			| timer2_event_in;
		uart1_d[irq_pkg::UART1_RX_FLAG_BIT] =
			uart1_d[irq_pkg::UART1_RX_FLAG_BIT] | uart1_rx_in;
		uart1_d[irq_pkg::UART1_TX_FLAG_BIT] =
			uart1_d[irq_pkg::UART1_TX_FLAG_BIT] | uart1_tx_in;
		// The extended flag re-sets while any enabled event flag remains.
		exif_d[irq_pkg::EXT_FLAG_LSB +: 4] =
			exif_d[irq_pkg::EXT_FLAG_LSB +: 4] | grp_req;
	end

	// ========================================================================
	// Priority resolution and nesting.
	// ========================================================================
	logic [11:0] pend, tier;
	logic [3:0] sel1, sel0;
	logic any1, any0;

	always_comb begin
		// Polling order is ascending interrupt number; 4 and 6 are reserved.
		pend = {eie_q[3:0] & exif_q[irq_pkg::EXT_FLAG_LSB +: 4] & grp_req,
			ie_q[6] & (|uart1_q[1:0]), 1'b0,
			ie_q[5] & t2_q[irq_pkg::TIMER2_FLAG_BIT], 1'b0,
			ie_q[3] & tctl_q[irq_pkg::TIMER1_FLAG_BIT],
			ie_q[2] & tctl_q[irq_pkg::PIN1_FLAG_BIT],
			ie_q[1] & tctl_q[irq_pkg::TIMER0_FLAG_BIT],
			ie_q[0] & tctl_q[irq_pkg::PIN0_FLAG_BIT]};
		pend = pend & {12{ie_q[irq_pkg::GLOBAL_IRQ_ENABLE_BIT]}};
		tier = {pri_ext_q[3:0], pri_base_q[6], 1'b0, pri_base_q[5], 1'b0,
			pri_base_q[3:0]};
		sel1 = 4'h0;
		sel0 = 4'h0;
		any1 = 1'b0;
		any0 = 1'b0;
		for (int i = irq_pkg::NUM_IRQS - 1; i >= 0; i--) begin
			if (pend[i] && tier[i]) begin
				sel1 = 4'(i);
				any1 = 1'b1;
			end
			if (pend[i] && !tier[i]) begin
				sel0 = 4'(i);
				any0 = 1'b1;
			end
		end
		in_service_d = in_service_q;
		if (irq_return_in) begin
			// Return closes the innermost service and resumes the outer.
			if (in_service_q[1]) begin
				in_service_d[1] = 1'b0;
			end else begin
				in_service_d[0] = 1'b0;
			end
		end
		if (ack_take) begin
			in_service_d[req_q.tier] = 1'b1;
		end
		req_d = '0;
		if (!ack_take) begin
			if (any1 && !in_service_q[1]) begin
				req_d.valid = 1'b1;
				req_d.tier = 1'b1;
				req_d.number = sel1;
			end else if (any0 && in_service_q == 2'b00) begin
				req_d.valid = 1'b1;
				req_d.number = sel0;
			end
		end
		req_d.vector = {1'b0, req_d.number, irq_pkg::VECTOR_LOW_BITS};
	end

	// ========================================================================
	// Read port: every flag and enable is visible for polling.
	// ========================================================================
	always_comb begin
		rdata_d = irq_pkg::RESET_BYTE;
		case (sfr_addr_in)
			irq_pkg::ADDR_IRQ_ENABLE_BASE: rdata_d = ie_q;
			irq_pkg::ADDR_IRQ_ENABLE_EXTENDED: rdata_d = eie_q;
			irq_pkg::ADDR_IRQ_PRIORITY_BASE: rdata_d = pri_base_q;
			irq_pkg::ADDR_IRQ_PRIORITY_EXTENDED: rdata_d = pri_ext_q;
			irq_pkg::ADDR_EXT_IRQ_CLOCK_GATE: rdata_d = gate_q;
			irq_pkg::ADDR_PIN_MODE: rdata_d = pin_mode_q;
			irq_pkg::ADDR_TIMER_CONTROL_REG: rdata_d = tctl_q;
			irq_pkg::ADDR_TIMER2_FLAGS: rdata_d = t2_q;
			irq_pkg::ADDR_UART1_FLAGS: rdata_d = uart1_q;
			irq_pkg::ADDR_EXT_IRQ_FLAGS: rdata_d = exif_q;
			default: begin
				for (int k = 0; k < irq_pkg::NUM_GROUPS; k++) begin
					if (sfr_addr_in == irq_pkg::ADDR_GROUP_BASE + 16'(2*k)) begin
						rdata_d = grp_en[k];
					end
					if (sfr_addr_in == irq_pkg::ADDR_GROUP_BASE
						+ 16'(2*k+1)) begin
						rdata_d = grp_flag[k];
					end
				end
			end
		endcase
	end

	// ========================================================================
	// State registers.
	// ========================================================================
	always_ff @(posedge clk_sys_in) begin
		if (reset_all) begin
			ie_q <= irq_pkg::RESET_BYTE;
			eie_q <= irq_pkg::RESET_BYTE;
			pri_base_q <= irq_pkg::RESET_BYTE;
			pri_ext_q <= irq_pkg::RESET_BYTE;
			tctl_q <= irq_pkg::RESET_BYTE;
			exif_q <= irq_pkg::RESET_BYTE;
			t2_q <= irq_pkg::RESET_BYTE;
			uart1_q <= irq_pkg::RESET_BYTE;
			gate_q <= irq_pkg::GATE_RESET;
			pin_mode_q <= irq_pkg::RESET_BYTE;
			rdata_q <= irq_pkg::RESET_BYTE;
			pin_prev_q <= irq_pkg::PIN_IDLE;
			in_service_q <= 2'h0;
			req_q <= '0;
		end else begin
			ie_q <= ie_d;
			eie_q <= eie_d;
			pri_base_q <= pri_base_d;
			pri_ext_q <= pri_ext_d;
			tctl_q <= tctl_d;
			exif_q <= exif_d;
			t2_q <= t2_d;
			uart1_q <= uart1_d;
			gate_q <= gate_d;
			pin_mode_q <= pin_mode_d;
			rdata_q <= rdata_d;
			pin_prev_q <= ext_pin_n_in;
			in_service_q <= in_service_d;
			req_q <= req_d;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign irq_req_out = req_q;
	assign in_service_out = in_service_q;

endmodule

// ===== testbench/irq_core_model.sv
`timescale 1ns/1ps
module irq_core_model (
	input wire clk_sys_in,
	input wire irq_pkg::irq_req_t irq_req_in,
	output logic irq_ack_out,
	output logic irq_return_out
);
	initial begin
		irq_ack_out = 1'b0;
		irq_return_out = 1'b0;
	end
	// ====================================================================
	// Takes the vector on show after a delay, so answers come fast or slow.
	task automatic take(input int delay, output irq_pkg::irq_req_t seen);
		int n;
		n = 0;
		repeat (delay + 1) @(negedge clk_sys_in);
		while (irq_req_in.valid !== 1'b1 && n < 40) begin
			@(negedge clk_sys_in);
			n++;
		end
		seen = irq_req_in;
		irq_ack_out = seen.valid;
		@(negedge clk_sys_in);
		irq_ack_out = 1'b0;
	endtask
	// Ends only the innermost service, so the outer one resumes.
	task automatic finish();
		@(negedge clk_sys_in);
		irq_return_out = 1'b1;
		@(negedge clk_sys_in);
		irq_return_out = 1'b0;
	endtask
endmodule

// ===== testbench/irq_controller_properties.sv
`timescale 1ns/1ps
module irq_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic power_on_brownout_reset_in,
	input wire logic external_reset_pin_in,
	input wire logic watchdog_timer_reset_in,
	input wire logic power_recovery_in,
	input wire logic wakeup_in,
	input wire logic debug_event_in,
	input wire logic [15:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic irq_ack_in,
	input wire logic irq_return_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire irq_pkg::irq_req_t irq_req_out,
	input wire logic [1:0] in_service_out
);
	// ====================================================================
	// Shadow of the global enable, taken from register writes.
	logic cause;
	logic glob_d;
	logic glob_q;
	assign cause = power_on_brownout_reset_in | external_reset_pin_in |
		watchdog_timer_reset_in | power_recovery_in | wakeup_in |
		debug_event_in;
	always_comb begin
		glob_d = glob_q;
		if (rst_in || cause) begin
			glob_d = 1'b0;
		end else if (sfr_wr_in &&
			sfr_addr_in == irq_pkg::ADDR_IRQ_ENABLE_BASE) begin
			glob_d = sfr_wdata_in[irq_pkg::GLOBAL_IRQ_ENABLE_BIT];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		glob_q <= glob_d;
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence acked;
		irq_req_out.valid && irq_ack_in;
	endsequence
	sequence both_open;
		in_service_out == 2'h3 && irq_return_in && !irq_ack_in;
	endsequence
	reset_cause_a: assert property (cause |=> irq_req_out == '0 &&
		in_service_out == 2'h0 && sfr_rdata_out == 8'h00)
		else $error("outputs not cleared by reset cause");
	vector_form_a: assert property (irq_req_out.valid |->
		irq_req_out.vector == {1'b0, irq_req_out.number, 3'h3})
		else $error("vector does not match number");
	reserved_skip_a: assert property (irq_req_out.valid |->
		irq_req_out.number < 4'hc && irq_req_out.number != 4'h4 &&
		irq_req_out.number != 4'h6) else $error("reserved number shown");
	ack_drops_a: assert property (acked |=> !irq_req_out.valid)
		else $error("request held after ack");
	open_tier0_a: assert property ((acked ##0 (!irq_req_out.tier &&
		!irq_return_in && !cause)) |=> in_service_out[0])
		else $error("tier 0 service not opened");
	open_tier1_a: assert property ((acked ##0 (irq_req_out.tier &&
		!irq_return_in && !cause)) |=> in_service_out[1])
		else $error("tier 1 service not opened");
	tier0_blocked_a: assert property (in_service_out != 2'h0 |->
		!(irq_req_out.valid && !irq_req_out.tier))
		else $error("tier 0 shown during service");
	tier1_blocked_a: assert property (in_service_out[1] |->
		!irq_req_out.valid) else $error("request during tier 1 service");
	pop_inner_a: assert property (both_open |=> in_service_out == 2'h1)
		else $error("return did not resume outer service");
	global_gate_a: assert property (!$past(glob_q) |->
		!irq_req_out.valid) else $error("request with global enable off");
endmodule
bind irq_controller irq_checker irq_checker_inst (.clk_sys_in, .rst_in,
	.power_on_brownout_reset_in, .external_reset_pin_in,
	.watchdog_timer_reset_in, .power_recovery_in, .wakeup_in,
	.debug_event_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .irq_ack_in,
	.irq_return_in, .sfr_rdata_out, .irq_req_out, .in_service_out);

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] a_ie = irq_pkg::ADDR_IRQ_ENABLE_BASE;
	localparam logic [15:0] a_prb = irq_pkg::ADDR_IRQ_PRIORITY_BASE;
	localparam logic [15:0] a_prx = irq_pkg::ADDR_IRQ_PRIORITY_EXTENDED;
	localparam logic [15:0] a_gate = irq_pkg::ADDR_EXT_IRQ_CLOCK_GATE;
	localparam logic [15:0] a_grp = irq_pkg::ADDR_GROUP_BASE;
	localparam logic [15:0] a_exf = irq_pkg::ADDR_EXT_IRQ_FLAGS;
	logic clk_sys_in = 1'b0;
	logic [6:0] cause = 7'h40;
	logic [3:0] pin_n = 4'hf;
	logic [4:0] ev = 5'h00;
	logic [29:0] grp = '0;
	logic [15:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 1'b0;
	logic ack;
	logic ret;
	logic [7:0] rbus;
	logic [7:0] rdata;
	logic [7:0] v;
	irq_pkg::irq_req_t req;
	irq_pkg::irq_req_t seen;
	logic [1:0] busy;
	int fail_count = 0;
	int checked = 0;
	int seed = 21;
	int e;
	logic [7:0] ebit [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h40};
	logic [3:0] num [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h7};
	always #4 clk_sys_in = ~clk_sys_in;
	irq_controller irq_controller_inst (.clk_sys_in(clk_sys_in),
		.rst_in(cause[6]), .power_on_brownout_reset_in(cause[0]),
		.external_reset_pin_in(cause[1]), .watchdog_timer_reset_in(cause[2]),
		.power_recovery_in(cause[3]), .wakeup_in(cause[4]),
		.debug_event_in(cause[5]), .ext_pin_n_in(pin_n),
		.timer0_overflow_in(ev[0]), .timer1_overflow_in(ev[1]),
		.timer2_event_in(ev[2]), .uart1_rx_in(ev[3]), .uart1_tx_in(ev[4]),
		.group_event_in(grp), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
		.sfr_wr_in(wr), .irq_ack_in(ack), .irq_return_in(ret),
		.sfr_rdata_out(rbus), .irq_req_out(req), .in_service_out(busy));
	irq_core_model irq_core_model_inst (.clk_sys_in(clk_sys_in),
		.irq_req_in(req), .irq_ack_out(ack), .irq_return_out(ret));
	// ====================================================================
	// Expectations and bus tasks.
	function automatic logic [7:0] exp_vec(input logic [3:0] n);
		return 8'(n) * 8'h08 + 8'h03;
	endfunction
	task automatic check(input logic [15:0] seen_v, input logic [15:0] exp);
		checked++;
		if (seen_v !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen_v, exp);
		end
	endtask
	task automatic wrt(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_sys_in);
		wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge clk_sys_in);
		addr = a;
		@(negedge clk_sys_in);
		rdata = rbus;
	endtask
	task automatic wrc(input logic [15:0] a, input logic [7:0] d, m);
		wrt(a, d);
		rd(a);
		check(rdata & m, d & m);
	endtask
	task automatic raise(input int k, input logic lv);
		@(negedge clk_sys_in);
		if (k == 0 || k == 2) pin_n[k / 2] = !lv;
		else ev[(k == 1) ? 0 : k - 2] = lv;
	endtask
	task automatic pulse(input int k);
		raise(k, 1'b1);
		raise(k, 1'b0);
	endtask
	task automatic take(input logic [3:0] n, input logic t, input int d);
		irq_core_model_inst.take(d, seen);
		check(seen.valid, 1'b1);
		check(seen.number, n);
		check(seen.tier, t);
		check(seen.vector, exp_vec(n));
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		fail_count++;
		results();
	end
	initial begin
		repeat (16) @(negedge clk_sys_in);
		cause = 7'h00;
		check(req, 14'h0);
		check(busy, 2'h0);
		rd(a_gate);
		check(rdata, irq_pkg::GATE_RESET);
		wrc(a_gate, irq_pkg::GATE_RESET, 8'hff);
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wrc(a_prb, v, 8'h6f);
			wrc(a_prx, v, 8'h0f);
			wrc(a_gate, v, 8'h0f);
			wrc(irq_pkg::ADDR_PIN_MODE, v, 8'hff);
			wrt(16'h0004, v);
			rd(16'h0004);
			check(rdata, 8'h00);
			check(rbus, 8'h00);
		end
		wrc(a_prb, 8'h00, 8'hff);
		wrc(a_prx, 8'h00, 8'hff);
		wrt(a_gate, irq_pkg::GATE_RESET);
		for (int k = 0; k < 7; k++) begin
			wrt(a_ie, 8'h80 | ebit[k]);
			raise(k, 1'b1);
			if (k != 0 && k != 2) raise(k, 1'b0);
			take(num[k], 1'b0, k);
			raise(k, 1'b0);
			wrt(irq_pkg::ADDR_TIMER2_FLAGS, 8'h00);
			wrt(irq_pkg::ADDR_UART1_FLAGS, 8'h00);
			check(busy, 2'h1);
			irq_core_model_inst.finish();
			check(busy, 2'h0);
		end
		wrt(a_ie, 8'h8a);
		for (int p = 0; p < 2; p++) begin
			wrt(a_prb, p ? 8'h08 : 8'h00);
			@(negedge clk_sys_in);
			ev[1:0] = 2'h3;
			@(negedge clk_sys_in);
			ev[1:0] = 2'h0;
			take(p ? 4'h3 : 4'h1, p[0], 0);
			irq_core_model_inst.finish();
			take(p ? 4'h1 : 4'h3, 1'b0, 2);
			irq_core_model_inst.finish();
		end
		pulse(1);
		take(4'h1, 1'b0, 0);
		pulse(1);
		repeat (4) @(negedge clk_sys_in);
		check(req.valid, 1'b0);
		pulse(3);
		take(4'h3, 1'b1, 1);
		check(busy, 2'h3);
		irq_core_model_inst.finish();
		check(busy, 2'h1);
		irq_core_model_inst.finish();
		take(4'h1, 1'b0, 0);
		irq_core_model_inst.finish();
		wrt(a_prb, 8'h00);
		e = $unsigned($random(seed)) % 8;
		wrt(a_grp, 8'h01 << e);
		wrt(irq_pkg::ADDR_IRQ_ENABLE_EXTENDED, 8'h01);
		wrt(a_ie, 8'h00);
		@(negedge clk_sys_in);
		grp[e] = 1'b1;
		@(negedge clk_sys_in);
		grp = '0;
		repeat (6) @(negedge clk_sys_in);
		check(req.valid, 1'b0);
		rd(a_grp + 16'h0001);
		check(rdata, 8'h01 << e);
		wrt(a_ie, 8'h80);
		take(4'h8, 1'b0, 3);
		rd(a_grp);
		v = rdata;
		rd(a_grp + 16'h0001);
		check(v & rdata, 8'h01 << e);
		wrt(a_exf, 8'h00);
		rd(a_exf);
		check(rdata[irq_pkg::EXT_FLAG_LSB], 1'b1);
		wrt(a_grp + 16'h0001, 8'h00);
		wrt(a_exf, 8'h00);
		rd(a_exf);
		check(rdata, 8'h00);
		irq_core_model_inst.finish();
		repeat (4) @(negedge clk_sys_in);
		check(req.valid, 1'b0);
		wrt(a_gate, 8'h00);
		@(negedge clk_sys_in);
		grp = 30'($random(seed));
		@(negedge clk_sys_in);
		grp = '0;
		for (int g = 0; g < 4; g++) begin
			rd(a_grp + 16'(2 * g + 1));
			check(rdata, 8'h00);
		end
		wrt(a_gate, irq_pkg::GATE_RESET);
		// Edge mode: a pin held low raises one request only.
		wrt(irq_pkg::ADDR_TIMER_CONTROL_REG, 8'h01);
		wrt(a_ie, 8'h81);
		raise(0, 1'b1);
		take(4'h0, 1'b0, 0);
		irq_core_model_inst.finish();
		repeat (4) @(negedge clk_sys_in);
		check(req.valid, 1'b0);
		raise(0, 1'b0);
		for (int c = 0; c < 7; c++) begin
			wrt(a_ie, 8'h81);
			@(negedge clk_sys_in);
			cause = 7'h01 << c;
			@(negedge clk_sys_in);
			cause = 7'h00;
			rd(a_ie);
			check(rdata, irq_pkg::RESET_BYTE);
		end
		results();
	end
endmodule
